// >>> include/wls_pkg.sv
`default_nettype none
package wls_pkg;
  // clock and timing
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned T_MOD_NS      = 15;
  localparam int unsigned T_MOD_NCK     = 12;
  localparam int unsigned T_MOD_NS_CYC  =
    (T_MOD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned T_MOD_CYC     =
    (T_MOD_NS_CYC > T_MOD_NCK) ? T_MOD_NS_CYC : T_MOD_NCK;
  localparam logic [3:0]  T_MOD_CNT     = 4'(T_MOD_CYC);
  // data bus
  localparam int unsigned DQ_W          = 16;
  localparam int unsigned PRIME_LO      = 0;
  localparam int unsigned PRIME_HI      = 8;
  // mode register select codes and address bits
  localparam logic [2:0]  MRS_SEL_ONE   = 3'h1;
  localparam logic [2:0]  MRS_SEL_TWO   = 3'h2;
  localparam int unsigned MR1_WL_BIT    = 7;
  localparam int unsigned MR1_QOFF_BIT  = 12;
  localparam int unsigned MR2_ASR_BIT   = 6;
  localparam int unsigned MR2_SRT_BIT   = 7;
  // register map (byte addresses)
  localparam logic [3:0]  OFS_CTRL      = 4'h0;
  localparam logic [3:0]  OFS_STATUS    = 4'h4;
  localparam logic [3:0]  OFS_SREF      = 4'h8;
  localparam int unsigned CTRL_X8_BIT   = 0;
  localparam int unsigned CTRL_EXT_BIT  = 1;
  localparam logic [1:0]  CTRL_RESET    = 2'h0;
  // self-refresh rate codes and axi response codes
  localparam logic [1:0]  SR_NORMAL     = 2'h0;
  localparam logic [1:0]  SR_EXTENDED   = 2'h1;
  localparam logic [1:0]  SR_AUTO       = 2'h2;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  // leveling states, gray along idle-undef-feed-exit
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_UNDEF = 2'b01,
    ST_FEED  = 2'b11,
    ST_EXIT  = 2'b10
  } wls_state_e;
endpackage
`default_nettype wire

// >>> logic/wls_top.sv
// How it works
// [RL1] controller sets leveling bit via mode write
// [RL2] controller sends only idle commands meanwhile
// [RL3] other ranks disabled by output-off bit
// [RL4] odt honoured only tMOD after entry
// [RL5] strobe termination on before strobe driven
// [RL6] controller sends single strobe edge later
// [RL7] rising strobe captures clock onto data
// [RL8] feedback on bit 0, and 8 too unless x8 mode is set
// [RL9] other data bits low after first sample
// [RL10] no read strobe with feedback
// [RL11] controller sweeps delay, locks on rise
// [RL12] strobe pulses meet normal write widths
// [RL13] data undefined until first feedback
// [RL14] strobe stops; data undefined until tMOD
// [RL15] odt low before exit mode write
// [RL16] any command after tMOD from exit
// [RL17] auto self-refresh selects automatic rate
// [RL18] manual rate follows temperature range bit
// [RL19] range bit zero while auto enabled
// [RL20] range bit zero without extended support
// [RL21] leveling odt switches strobe term only
// [RL22] sample held until next rising strobe
`timescale 1ns/100ps
`default_nettype none
module wls_top
  import wls_pkg::*;
(
  // clock and reset
  input  wire  logic              aclk,
  input  wire  logic              aresetn,
  // axi4-lite write address, data and response
  input  wire  logic [3:0]        awaddr,
  input  wire  logic              awvalid,
  output logic                    awready,
  input  wire  logic [31:0]       wdata,
  input  wire  logic [3:0]        wstrb,
  input  wire  logic              wvalid,
  output logic                    wready,
  output logic [1:0]              bresp,
  output logic                    bvalid,
  input  wire  logic              bready,
  // axi4-lite read
  input  wire  logic [3:0]        araddr,
  input  wire  logic              arvalid,
  output logic                    arready,
  output logic [31:0]             rdata,
  output logic [1:0]              rresp,
  output logic                    rvalid,
  input  wire  logic              rready,
  // memory-side pins
  input  wire  logic              mrs_valid,
  input  wire  logic [2:0]        mrs_sel,
  input  wire  logic [13:0]       mrs_addr,
  input  wire  logic              odt_in,
  input  wire  logic              ck_in,
  input  wire  logic              dqs_in,
  output logic [DQ_W-1:0]         dq_out,
  output logic [DQ_W-1:0]         dq_oe,
  output logic                    dqs_oe,
  output logic                    dqs_term_on,
  output logic                    dq_term_on,
  output logic                    fb_defined,
  // self-refresh configuration
  output logic                    auto_self_refresh_enable,
  output logic                    self_refresh_temp_range,
  output logic [1:0]              sr_rate_sel
);

  ////////////////////////////////////////////////////////////////////////////
  // mode registers and leveling state
  wls_state_e   state_reg;            // leveling phase
  logic [3:0]   mod_cnt_reg;          // tMOD down-counter
  logic         odt_ready_reg;        // odt may be honoured
  logic         qoff_reg;             // output buffer off
  logic         dqs_prev_reg;         // strobe one cycle ago
  logic [1:0]   ctrl_reg;             // x8 mode, extended support
  logic         mr1_write;
  logic         dqs_rise;

  assign mr1_write = mrs_valid && (mrs_sel == MRS_SEL_ONE);
  assign dqs_rise  = dqs_in && !dqs_prev_reg;

  // strobe edge detector
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      dqs_prev_reg <= 1'b0;
    else
      dqs_prev_reg <= dqs_in;
  end

  // leveling sequencer, entry and exit by mode writes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg   <= ST_IDLE;
      mod_cnt_reg <= 4'h0;
      qoff_reg    <= 1'b0;
    end
    else
    begin
      if (mr1_write)
        qoff_reg <= mrs_addr[MR1_QOFF_BIT]; // RL3
      if (mod_cnt_reg != 4'h0)
        mod_cnt_reg <= mod_cnt_reg - 4'h1;
      unique case (state_reg)
        ST_IDLE:
        begin
          // entry on leveling bit set
          if (mr1_write && mrs_addr[MR1_WL_BIT])
          begin
            state_reg   <= ST_UNDEF; // RL1
            mod_cnt_reg <= T_MOD_CNT;
          end
        end
        ST_UNDEF, ST_FEED:
        begin
          if (mr1_write && !mrs_addr[MR1_WL_BIT])
          begin
            state_reg   <= ST_EXIT; // RL14
            mod_cnt_reg <= T_MOD_CNT;
          end
          else if (state_reg == ST_UNDEF && dqs_rise)
            state_reg <= ST_FEED; // RL13
        end
        ST_EXIT:
        begin
          // data stays undefined until tMOD has run out
          if (mod_cnt_reg == 4'h1)
            state_reg <= ST_IDLE; // RL16
        end
      endcase
    end
  end

  // odt gate: ignored during the first tMOD of leveling
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      odt_ready_reg <= 1'b1;
    else if (state_reg == ST_IDLE && mr1_write && mrs_addr[MR1_WL_BIT])
      odt_ready_reg <= 1'b0; // RL4
    else if (mod_cnt_reg == 4'h1)
      odt_ready_reg <= 1'b1; // RL4
  end

  ////////////////////////////////////////////////////////////////////////////
  // termination: in leveling odt drives only the strobe termination
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      dqs_term_on <= 1'b0;
      dq_term_on  <= 1'b0;
    end
    else if (state_reg == ST_UNDEF || state_reg == ST_FEED)
    begin
      dqs_term_on <= odt_in && odt_ready_reg; // RL5
      dq_term_on  <= 1'b0;                    // RL21
    end
    else
    begin
      dqs_term_on <= odt_in;
      dq_term_on  <= odt_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // feedback path: one-cycle latency keeps well inside tWLO
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      dq_out     <= '0;
      dq_oe      <= '0;
      fb_defined <= 1'b0;
    end
    else if ((state_reg == ST_UNDEF || state_reg == ST_FEED) && dqs_rise)
    begin
      // capture clock level; non-prime bits go low
      dq_out           <= '0;               // RL9
      dq_out[PRIME_LO] <= ck_in;            // RL7 RL8
      dq_out[PRIME_HI] <= ck_in && !ctrl_reg[CTRL_X8_BIT]; // RL8
      dq_oe            <= qoff_reg ? '0 : '1;
      fb_defined       <= !qoff_reg;
    end
    else if (state_reg == ST_UNDEF)
    begin
      // undefined drive phase, flagged for the controller
      dq_oe      <= qoff_reg ? '0 : '1;     // RL13
      fb_defined <= 1'b0;                   // RL13
    end
    else if (state_reg == ST_EXIT || (state_reg == ST_IDLE
             && mr1_write && mrs_addr[MR1_WL_BIT]))
      fb_defined <= 1'b0;                   // RL14
    else if (state_reg == ST_IDLE)
      dq_oe <= '0;
    // in ST_FEED without an edge the sample is held  // RL22
  end

  // read strobes never driven with feedback
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      dqs_oe <= 1'b0;
    else
      dqs_oe <= 1'b0; // RL10
  end

  ////////////////////////////////////////////////////////////////////////////
  // second mode register: self-refresh temperature handling
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      auto_self_refresh_enable <= 1'b0;
      self_refresh_temp_range  <= 1'b0;
      sr_rate_sel              <= SR_NORMAL;
    end
    else if (mrs_valid && mrs_sel == MRS_SEL_TWO)
    begin
      auto_self_refresh_enable <= mrs_addr[MR2_ASR_BIT];
      self_refresh_temp_range  <= mrs_addr[MR2_SRT_BIT];
      // illegal pair falls back to automatic; no extended part: normal
      if (mrs_addr[MR2_ASR_BIT])
        sr_rate_sel <= SR_AUTO;                       // RL17
      else if (mrs_addr[MR2_SRT_BIT] && ctrl_reg[CTRL_EXT_BIT])
        sr_rate_sel <= SR_EXTENDED;                   // RL18
      else
        sr_rate_sel <= SR_NORMAL;                     // RL18
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave: address and data taken together, one cycle
  logic wr_go;
  assign wr_go = awvalid && wvalid && awready && wready;

  // write channel handshake and response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
      ctrl_reg <= CTRL_RESET;
    end
    else
    begin
      awready <= !awready && !bvalid && awvalid && wvalid;
      wready  <= !wready && !bvalid && awvalid && wvalid;
      if (wr_go)
      begin
        bvalid <= 1'b1;
        if (awaddr == OFS_CTRL)
        begin
          bresp <= RESP_OKAY;
          if (wstrb[0])
            ctrl_reg <= wdata[1:0];
        end
        else if (awaddr == OFS_STATUS || awaddr == OFS_SREF)
          bresp <= RESP_OKAY; // read-only, write ignored
        else
          bresp <= RESP_SLVERR;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end

  // read channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= RESP_OKAY;
    end
    else
    begin
      arready <= !arready && !rvalid && arvalid;
      if (arready && arvalid)
      begin
        rvalid <= 1'b1;
        rresp  <= RESP_OKAY;
        unique case (araddr)
          OFS_CTRL:   rdata <= {30'h0, ctrl_reg};
          OFS_STATUS: rdata <= {24'h0, fb_defined, qoff_reg, odt_ready_reg,
                                dq_out[PRIME_HI], dq_out[PRIME_LO],
                                state_reg == ST_EXIT, state_reg};
          OFS_SREF:   rdata <= {27'h0, auto_self_refresh_enable
                                && self_refresh_temp_range, sr_rate_sel,
                                self_refresh_temp_range,
                                auto_self_refresh_enable};
          default:
          begin
            rdata <= 32'h0;
            rresp <= RESP_SLVERR;
          end
        endcase
      end
      else if (rvalid && rready)
        rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic lvl;
  assign lvl = state_reg == ST_UNDEF || state_reg == ST_FEED;

  // cycles since leveling entry, saturating; a long hold is counted here
  // rather than unrolled as a repetition in the property
  logic [3:0]   since_entry_reg;      // 1 in the cycle after entry
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      since_entry_reg <= 4'hF;
    else if (state_reg == ST_IDLE && mr1_write && mrs_addr[MR1_WL_BIT])
      since_entry_reg <= 4'h1;
    else if (since_entry_reg != 4'hF)
      since_entry_reg <= since_entry_reg + 4'h1;
  end

  dq_term_off_a: assert property (lvl |=> !dq_term_on) // RL21
    else $error("data termination on during leveling");
  odt_wait_a: assert property ( // RL4
    lvl && since_entry_reg <= T_MOD_CNT |-> !odt_ready_reg)
    else $error("odt honoured before tMOD");
  odt_open_a: assert property ( // RL4
    lvl && since_entry_reg > T_MOD_CNT |-> odt_ready_reg)
    else $error("odt gate still closed after tMOD");
  strobe_term_a: assert property ( // RL5
    lvl && odt_ready_reg && odt_in |=> dqs_term_on)
    else $error("strobe termination missing");
  fb_capture_a: assert property ( // RL7
    lvl && dqs_rise && !qoff_reg
    |=> dq_out[PRIME_LO] == $past(ck_in) && fb_defined)
    else $error("feedback not captured");
  lane_copy_a: assert property ( // RL8
    state_reg == ST_FEED && !ctrl_reg[CTRL_X8_BIT]
    |-> dq_out[PRIME_HI] == dq_out[PRIME_LO])
    else $error("upper lane feedback mismatch");
  others_low_a: assert property ( // RL9
    state_reg == ST_FEED |-> (dq_out & ~(16'h0101)) == 16'h0000)
    else $error("non-prime bit driven high");
  no_strobe_a: assert property (!dqs_oe) // RL10
    else $error("read strobe driven");
  undef_flag_a: assert property ( // RL13
    state_reg == ST_UNDEF && !dqs_rise |=> !fb_defined)
    else $error("undefined phase flagged valid");
  hold_sample_a: assert property ( // RL22
    state_reg == ST_FEED && !dqs_rise && !mr1_write |=> $stable(dq_out))
    else $error("sample changed without strobe");
  auto_rate_a: assert property ( // RL17
    mrs_valid && mrs_sel == MRS_SEL_TWO && mrs_addr[MR2_ASR_BIT]
    |=> sr_rate_sel == SR_AUTO)
    else $error("auto self-refresh not selected");
  manual_rate_a: assert property ( // RL18
    mrs_valid && mrs_sel == MRS_SEL_TWO
    && !mrs_addr[MR2_ASR_BIT] && !mrs_addr[MR2_SRT_BIT]
    |=> sr_rate_sel == SR_NORMAL)
    else $error("manual rate wrong");

  entry_c: cover property (state_reg == ST_IDLE ##1 state_reg == ST_UNDEF);
  rise_c:  cover property (state_reg == ST_FEED && dqs_rise && ck_in);
  exit_c:  cover property (state_reg == ST_EXIT ##1 state_reg == ST_IDLE);
  axi_c:   cover property (wr_go ##[1:4] (arready && arvalid));

endmodule // wls_top
`default_nettype wire

// >>> dv/wls_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
module wls_ctrl_model
  import wls_pkg::*;
(
  // bench clock
  input  wire logic        aclk,
  // commands, termination, clock and strobe toward the device
  output var  logic        mrs_valid,
  output var  logic [2:0]  mrs_sel,
  output var  logic [13:0] mrs_addr,
  output var  logic        odt_in,
  output var  logic        ck_in,
  output var  logic        dqs_in
);
  ////////////////////////////////////////////////////////////////////////
  // idle levels at time zero
  initial
  begin
    mrs_valid = 1'b0;
    mrs_sel   = 3'h0;
    mrs_addr  = 14'h0;
    odt_in    = 1'b0;
    ck_in     = 1'b0;
    dqs_in    = 1'b0;
  end

  // memory clock runs free, seen as a level
  always @(posedge aclk)
    ck_in <= ~ck_in;

  ////////////////////////////////////////////////////////////////////////
  // one mode write, idle commands on both sides of it
  task automatic mode_write(input logic [2:0] sel, input logic [13:0] a);
    @(posedge aclk);
    mrs_valid <= 1'b1;
    mrs_sel   <= sel;
    mrs_addr  <= a;
    @(posedge aclk);
    mrs_valid <= 1'b0;
    // address is don't care now, so show garbage
    mrs_sel   <= ~sel;
    mrs_addr  <= ~a;
  endtask

  // termination request
  task automatic set_odt(input logic v);
    @(posedge aclk);
    odt_in <= v;
  endtask

  // swept delay, then one rising strobe edge; ck is the level it meets
  task automatic strobe_rise(input int gap, output logic ck);
    repeat (gap) @(posedge aclk);
    @(posedge aclk);
    dqs_in <= 1'b1;
    ck = ~ck_in;
  endtask

  // two cycles high, two low: normal write widths
  task automatic strobe_fall;
    repeat (2) @(posedge aclk);
    dqs_in <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask
endmodule // wls_ctrl_model
`default_nettype wire

// >>> dv/wls_top_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module wls_top_tb_top
  import wls_pkg::*;
;
  logic            aclk, aresetn, awvalid, awready, wvalid, wready;
  logic            bvalid, bready, arvalid, arready, rvalid, rready;
  logic [3:0]      awaddr, araddr, wstrb;
  logic [31:0]     wdata, rdata, rnd;
  logic [1:0]      bresp, rresp, sr_rate_sel;
  logic            mrs_valid, odt_in, ck_in, dqs_in, s1, s2;
  logic [2:0]      mrs_sel;
  logic [13:0]     mrs_addr;
  logic [DQ_W-1:0] dq_out, dq_oe;
  logic            dqs_oe, dqs_term_on, dq_term_on, fb_defined;
  logic            auto_self_refresh_enable, self_refresh_temp_range;
  int              fails, check_count;
  logic [33:0]     rq[$]; // read notes {rresp, rdata}
  logic [1:0]      bq[$]; // write response notes
  logic [16:0]     fq[$]; // feedback notes {fb_defined, dq_out}

  wls_top dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .mrs_valid, .mrs_sel,
    .mrs_addr, .odt_in, .ck_in, .dqs_in, .dq_out, .dq_oe, .dqs_oe,
    .dqs_term_on, .dq_term_on, .fb_defined, .auto_self_refresh_enable,
    .self_refresh_temp_range, .sr_rate_sel);
  wls_ctrl_model mdl (.aclk, .mrs_valid, .mrs_sel, .mrs_addr, .odt_in,
    .ck_in, .dqs_in);

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  task automatic check(input logic [33:0] got, input logic [33:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude;
    if (fails == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // result watcher: oldest note against each answer as it appears
  always @(posedge aclk)
  begin
    s1 <= dqs_in;
    s2 <= s1;
    if (bvalid && bready)
      check(bresp, bq.pop_front());
    if (rvalid && rready)
      check({rresp, rdata}, rq.pop_front());
    if (s1 && !s2)
      check({fb_defined, dq_out}, fq.pop_front());
  end

  // hang guard
  initial
  begin
    repeat (20000) @(posedge aclk);
    fails++;
    conclude();
  end

  ////////////////////////////////////////////////////////////////////////
  // register write; address and data released to their inverse
  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    bq.push_back(r);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do @(posedge aclk); while (!(awready && wready));
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    awaddr  <= ~a;
    wdata   <= ~d;
    while (!bvalid) @(posedge aclk);
    bready  <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [33:0] e);
    rq.push_back(e);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    araddr  <= ~a;
    while (!rvalid) @(posedge aclk);
    rready  <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // one full leveling pass, early odt, swept strobes, ordered exit
  task automatic level(input logic x8);
    logic ck;
    logic [15:0] pat;
    wr(OFS_CTRL, {31'h0, x8}, RESP_OKAY);
    rd(OFS_CTRL, {33'h0, x8});
    mdl.mode_write(MRS_SEL_ONE, 14'h0080);
    mdl.set_odt(1'b1);
    repeat (3) @(posedge aclk);
    check(dq_oe, 16'hFFFF);
    check(fb_defined, 1'b0);
    check(dqs_term_on, 1'b0);
    repeat (14) @(posedge aclk);
    check(dqs_term_on, 1'b1);
    check(dq_term_on, 1'b0);
    for (int k = 0; k < 6; k++)
    begin
      rnd = lfsr(rnd);
      mdl.strobe_rise(int'(rnd[1:0]), ck);
      pat = {7'h0, ck & ~x8, 7'h0, ck};
      fq.push_back({1'b1, pat});
      mdl.strobe_fall();
      check(dq_out, pat);
      check(dqs_oe, 1'b0);
    end
    // status while feeding back: fb, gate open, last sample, feed state
    rd(OFS_STATUS, {26'h0, 3'b101, pat[8], pat[0], 3'b011});
    mdl.set_odt(1'b0);
    repeat (3) @(posedge aclk);
    check(dqs_term_on, 1'b0);
    mdl.mode_write(MRS_SEL_ONE, 14'h0000);
    repeat (3) @(posedge aclk);
    check(fb_defined, 1'b0);
    check(dq_oe, 16'hFFFF);
    repeat (14) @(posedge aclk);
    check(dq_oe, 16'h0000);
  endtask

  // second mode register: every pair of bits, with and without ext
  task automatic sref(input logic [2:0] i);
    logic [1:0] rt;
    rt = i[0] ? SR_AUTO : (i[1] && i[2]) ? SR_EXTENDED : SR_NORMAL;
    wr(OFS_CTRL, {30'h0, i[2], 1'b0}, RESP_OKAY);
    mdl.mode_write(MRS_SEL_TWO, {6'h0, i[1], i[0], 6'h0});
    repeat (3) @(posedge aclk);
    check(auto_self_refresh_enable, i[0]);
    check(self_refresh_temp_range, i[1]);
    check(sr_rate_sel, rt);
    rd(OFS_SREF, {29'h0, i[0] & i[1], rt, i[1], i[0]});
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {awaddr, araddr, wdata} = 40'h0;
    wstrb = 4'hF;
    {s1, s2} = 2'h0;
    rnd = 32'h7D6364CA;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check({dq_oe, fb_defined, sr_rate_sel}, 34'h0);
    rd(OFS_CTRL, 34'h0);
    rd(OFS_STATUS, 34'h20);
    wr(4'hC, 32'h3, RESP_SLVERR);
    rd(4'hC, {RESP_SLVERR, 32'h0});
    wr(OFS_STATUS, 32'hFF, RESP_OKAY);
    for (int m = 0; m < 2; m++)
      level(m[0]);
    // other rank: outputs off during leveling
    mdl.mode_write(MRS_SEL_ONE, 14'h1080);
    repeat (3) @(posedge aclk);
    check(dq_oe, 16'h0000);
    mdl.mode_write(MRS_SEL_ONE, 14'h0000);
    repeat (14) @(posedge aclk);
    // outside leveling odt switches data termination as well
    mdl.set_odt(1'b1);
    repeat (2) @(posedge aclk);
    check({dqs_term_on, dq_term_on}, 2'h3);
    mdl.set_odt(1'b0);
    for (int i = 0; i < 8; i++)
      sref(i[2:0]);
    repeat (4) @(posedge aclk);
    conclude();
  end
endmodule // wls_top_tb_top
`default_nettype wire
